/* src/elpc_pkg.sv */
// Functional notes
// - core stacks on entry, restores on return
// - latch and arbitrate; latched request is never pre-empted
// - service only at boundary, mask clear, enabled; wait/stop wakes need no boundary, stop recovery end ignores the mask
// - highest pending priority served first
// - pending request served right after return
// - high index register is not stacked
// - software interrupt ignores the mask bit
// - software stacks pc, hardware stacks pc-1
// - reset, software, then sources one to sixteen
// - three read-only pending flag registers
// - reset highest, bypasses arbitration
// - break forces the software interrupt vector
// - break protects flags unless clear enable set
// - two-step clears stay protected during break
// - wait or stop clears the mask bit
// - wait gates core clocks, peripherals run
// - wake from wait stacks one cycle later
// - break during wait sets stop/wait flag
// - watchdog runs in wait unless disabled
// - stop resets counter, gates both clocks
// - recovery 4096 or 32 crystal cycles
// - counter held in stop, then times recovery
// - writing zero clears the stop/wait flag
package elpc_pkg;

  // register indices on the plain port
  localparam logic [2:0] ADDR_PEND_FIRST = 3'h0;
  localparam logic [2:0] ADDR_PEND_SECOND = 3'h1;
  localparam logic [2:0] ADDR_PEND_THIRD = 3'h2;
  localparam logic [2:0] ADDR_BRK_STATUS = 3'h3;
  localparam logic [2:0] ADDR_BRK_FLAG_CTRL = 3'h4;
  localparam logic [2:0] ADDR_CONFIG = 3'h5;

  // field positions
  localparam int BIT_STOP_WAIT_FLAG = 1;
  localparam int BIT_BRK_CLR_EN = 7;
  localparam int BIT_SHORT_REC = 0;
  localparam int BIT_WDOG_DIS = 1;

  // reset values
  localparam logic RST_BRK_CLR_EN = 1'b0;
  localparam logic RST_SHORT_REC = 1'b0;
  localparam logic RST_WDOG_DIS = 1'b0;

  // vector selectors handed to the core
  localparam logic [4:0] VEC_SWI = 5'h00;
  localparam logic [4:0] VEC_HW0 = 5'h01;

  // crystal clock enable divider and stop recovery lengths
  localparam logic [1:0] XTAL_DIV = 2'h2;
  localparam int LONG_REC_XTAL = 4096;
  localparam logic [12:0] SHORT_REC_XTAL = 13'h0020;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_STOP = 3'b010,
    ST_RECOV = 3'b011
  } elpc_state_t;

  // whole state of the block
  typedef struct packed {
    elpc_state_t state;
    logic latched;
    logic [4:0] vec;
    logic is_sw;
    logic take;
    logic restore;
    logic clr_imask;
    logic brk_state;
    logic stop_wait_flag;
    logic brk_clr_en;
    logic short_rec;
    logic wdog_dis;
    logic [1:0] xdiv;
    logic [12:0] rcnt;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic per_clk_en;
    logic bus_clk_en;
    logic xtal_clk_en;
    logic flag_clr_en;
    logic wdog_en;
  } elpc_regs_t;

endpackage

/* src/elpc_ctrl.sv */
`timescale 1ns/100ps
module elpc_ctrl import elpc_pkg::*; #(
  parameter int LONG_REC = LONG_REC_XTAL
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instr_done,
  input wire logic i_mask,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic vec_fetch,
  input wire logic brk_req,
  input wire logic [15:0] irq_req,
  input wire logic [15:0] irq_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic int_take,
  output logic [4:0] vector_sel,
  output logic stack_pc_minus1,
  output logic restore_req,
  output logic clr_imask,
  output logic brk_state,
  output logic flag_clr_en,
  output logic cpu_clk_en,
  output logic per_clk_en,
  output logic bus_clk_en,
  output logic xtal_clk_en,
  output logic wdog_en
);

  // index of the highest priority request, lowest bit wins
  function automatic logic [3:0] prio(input logic [15:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  elpc_regs_t s_reg; // registered state
  elpc_regs_t s_next; // next state
  logic [15:0] hw_live; // enabled requests
  logic hw_any; // any enabled request
  logic wake; // event that ends wait or stop
  logic [12:0] rec_last; // last count of recovery

  assign hw_live = irq_req & irq_en;
  assign hw_any = |hw_live;
  assign wake = brk_req | (hw_any & ~i_mask);
  assign rec_last = s_reg.short_rec ? (SHORT_REC_XTAL - 13'h0001) : 13'(LONG_REC - 1);

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.take = 1'b0;
    s_next.restore = 1'b0;
    s_next.clr_imask = 1'b0;
    s_next.rdata = 8'h00;
    // crystal clock enable divider
    s_next.xdiv = (s_reg.xdiv == XTAL_DIV - 2'h1) ? 2'h0 : s_reg.xdiv + 2'h1;
    // core acknowledges the vector, latch releases
    if (vec_fetch) begin
      s_next.latched = 1'b0;
    end
    // restore request on return, break state ends there
    if (rti_exec && instr_done) begin
      s_next.restore = 1'b1;
      s_next.brk_state = 1'b0;
    end
    unique case (s_reg.state)
      ST_RUN: begin
        // arbitration only at an instruction boundary
        if (instr_done && !s_reg.latched) begin
          if (brk_req) begin
            s_next.latched = 1'b1;
            s_next.vec = VEC_SWI;
            s_next.is_sw = 1'b1;
            s_next.take = 1'b1;
            s_next.brk_state = 1'b1;
          end else if (swi_exec) begin
            s_next.latched = 1'b1;
            s_next.vec = VEC_SWI;
            s_next.is_sw = 1'b1;
            s_next.take = 1'b1;
          end else if (hw_any && !i_mask) begin
            s_next.latched = 1'b1;
            s_next.vec = VEC_HW0 + {1'b0, prio(hw_live)};
            s_next.is_sw = 1'b0;
            s_next.take = 1'b1;
          end else if (wait_exec) begin
            s_next.state = ST_WAIT;
            s_next.clr_imask = 1'b1;
            s_next.cpu_clk_en = 1'b0;
          end else if (stop_exec) begin
            s_next.state = ST_STOP;
            s_next.clr_imask = 1'b1;
            s_next.cpu_clk_en = 1'b0;
            s_next.per_clk_en = 1'b0;
            s_next.bus_clk_en = 1'b0;
            s_next.xtal_clk_en = 1'b0;
            s_next.rcnt = 13'h0000;
          end
        end
      end
      ST_WAIT: begin
        // wake stacks on the very next cycle
        if (wake) begin
          s_next.state = ST_RUN;
          s_next.cpu_clk_en = 1'b1;
          s_next.latched = 1'b1;
          s_next.take = 1'b1;
          if (brk_req) begin
            s_next.vec = VEC_SWI;
            s_next.is_sw = 1'b1;
            s_next.brk_state = 1'b1;
            s_next.stop_wait_flag = 1'b1;
          end else begin
            s_next.vec = VEC_HW0 + {1'b0, prio(hw_live)};
            s_next.is_sw = 1'b0;
          end
        end
      end
      ST_STOP: begin
        // counter held at zero until an exit event
        s_next.rcnt = 13'h0000;
        if (wake) begin
          s_next.state = ST_RECOV;
          s_next.xtal_clk_en = 1'b1;
        end
      end
      ST_RECOV: begin
        // count crystal cycles, then resume and arbitrate
        if (s_reg.xdiv == 2'h0) begin
          if (s_reg.rcnt == rec_last) begin
            s_next.state = ST_RUN;
            s_next.cpu_clk_en = 1'b1;
            s_next.per_clk_en = 1'b1;
            s_next.bus_clk_en = 1'b1;
            if (brk_req) begin
              s_next.latched = 1'b1;
              s_next.vec = VEC_SWI;
              s_next.is_sw = 1'b1;
              s_next.brk_state = 1'b1;
              s_next.take = 1'b1;
            end else if (hw_any) begin
              s_next.latched = 1'b1;
              s_next.vec = VEC_HW0 + {1'b0, prio(hw_live)};
              s_next.is_sw = 1'b0;
              s_next.take = 1'b1;
            end
          end else begin
            s_next.rcnt = s_reg.rcnt + 13'h0001;
          end
        end
      end
      default: begin
        s_next.state = ST_RUN;
      end
    endcase
    // register writes
    if (wr) begin
      unique case (addr)
        ADDR_BRK_STATUS: begin
          // only a zero clears, a set event wins
          if (!wdata[BIT_STOP_WAIT_FLAG] && !(s_reg.state == ST_WAIT && brk_req)) begin
            s_next.stop_wait_flag = 1'b0;
          end
        end
        ADDR_BRK_FLAG_CTRL: begin
          s_next.brk_clr_en = wdata[BIT_BRK_CLR_EN];
        end
        ADDR_CONFIG: begin
          s_next.short_rec = wdata[BIT_SHORT_REC];
          s_next.wdog_dis = wdata[BIT_WDOG_DIS];
        end
        default: begin
        end
      endcase
    end
    // register reads, data stands one cycle later
    if (rd) begin
      unique case (addr)
        ADDR_PEND_FIRST: s_next.rdata = {irq_req[5:0], 2'b00};
        ADDR_PEND_SECOND: s_next.rdata = irq_req[13:6];
        ADDR_PEND_THIRD: s_next.rdata = {6'h00, irq_req[15:14]};
        ADDR_BRK_STATUS: s_next.rdata = 8'(s_reg.stop_wait_flag) << BIT_STOP_WAIT_FLAG;
        ADDR_BRK_FLAG_CTRL: s_next.rdata = 8'(s_reg.brk_clr_en) << BIT_BRK_CLR_EN;
        ADDR_CONFIG: s_next.rdata = {6'h00, s_reg.wdog_dis, s_reg.short_rec};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // peripheral flag clearing permission during break
    s_next.flag_clr_en = !s_next.brk_state || s_next.brk_clr_en;
    // watchdog runs in wait unless disabled
    s_next.wdog_en = !s_next.wdog_dis && (s_next.state != ST_STOP);
  end

  // state register, synchronous reset bypasses arbitration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.state <= ST_RUN;
      s_reg.brk_clr_en <= RST_BRK_CLR_EN;
      s_reg.short_rec <= RST_SHORT_REC;
      s_reg.wdog_dis <= RST_WDOG_DIS;
      s_reg.cpu_clk_en <= 1'b1;
      s_reg.per_clk_en <= 1'b1;
      s_reg.bus_clk_en <= 1'b1;
      s_reg.xtal_clk_en <= 1'b1;
      s_reg.flag_clr_en <= 1'b1;
      s_reg.wdog_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign rdata = s_reg.rdata;
  // take asks the core to stack its own registers only, never the high index
  assign int_take = s_reg.take;
  assign vector_sel = s_reg.vec;
  assign stack_pc_minus1 = !s_reg.is_sw;
  assign restore_req = s_reg.restore;
  assign clr_imask = s_reg.clr_imask;
  assign brk_state = s_reg.brk_state;
  assign flag_clr_en = s_reg.flag_clr_en;
  assign cpu_clk_en = s_reg.cpu_clk_en;
  assign per_clk_en = s_reg.per_clk_en;
  assign bus_clk_en = s_reg.bus_clk_en;
  assign xtal_clk_en = s_reg.xtal_clk_en;
  assign wdog_en = s_reg.wdog_en;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // boundary in run with nothing latched
  logic arb_ok;
  assign arb_ok = instr_done && (s_reg.state == ST_RUN) && !s_reg.latched;

  property p_hw_prio;
    arb_ok && !brk_req && !swi_exec && !i_mask && hw_any |=>
      int_take && vector_sel == VEC_HW0 + {1'b0, prio($past(hw_live))};
  endproperty
  a_hw_prio: assert property (p_hw_prio) else $error("wrong priority vector");

  property p_swi_unmasked;
    arb_ok && !brk_req && swi_exec |=> int_take && vector_sel == VEC_SWI;
  endproperty
  a_swi_unmasked: assert property (p_swi_unmasked) else $error("swi not taken");

  property p_masked;
    arb_ok && i_mask && !swi_exec && !brk_req |=> !int_take;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken");

  property p_pc_adjust;
    int_take |-> stack_pc_minus1 == (vector_sel != VEC_SWI);
  endproperty
  a_pc_adjust: assert property (p_pc_adjust) else $error("wrong pc adjust");

  property p_latch_hold;
    s_reg.latched && !vec_fetch |=> $stable(vector_sel) && s_reg.latched;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched vector moved");

  property p_wait_entry;
    arb_ok && wait_exec && !brk_req && !swi_exec && !(hw_any && !i_mask) |=>
      clr_imask && !cpu_clk_en && per_clk_en;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");

  property p_wait_clocks;
    s_reg.state == ST_WAIT |-> !cpu_clk_en && per_clk_en;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("wait clock gating");

  property p_wait_wake;
    s_reg.state == ST_WAIT && wake |=> int_take && cpu_clk_en;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("late wake stacking");

  property p_wait_brk_flag;
    s_reg.state == ST_WAIT && brk_req |=> s_reg.stop_wait_flag && brk_state;
  endproperty
  a_wait_brk_flag: assert property (p_wait_brk_flag) else $error("flag not set");

  property p_stop_clocks;
    s_reg.state == ST_STOP |-> !bus_clk_en && !xtal_clk_en && s_reg.rcnt == 13'h0000;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("stop not gated");

  property p_pend_read;
    rd && addr == ADDR_PEND_THIRD |=> rdata == {6'h00, $past(irq_req[15:14])};
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending read wrong");

  property p_brk_protect;
    brk_state && !s_reg.brk_clr_en |-> !flag_clr_en;
  endproperty
  a_brk_protect: assert property (p_brk_protect) else $error("flags unprotected");

  property p_brk_take;
    arb_ok && brk_req |=> int_take && vector_sel == VEC_SWI && brk_state;
  endproperty
  a_brk_take: assert property (p_brk_take) else $error("break not forced");

  property p_rti_restore;
    rti_exec && instr_done |=> restore_req;
  endproperty
  a_rti_restore: assert property (p_rti_restore) else $error("no restore on return");

  property p_stw_clear;
    wr && addr == ADDR_BRK_STATUS && !wdata[BIT_STOP_WAIT_FLAG] &&
      !(s_reg.state == ST_WAIT && brk_req) |=> !s_reg.stop_wait_flag;
  endproperty
  a_stw_clear: assert property (p_stw_clear) else $error("stop/wait flag kept");

  property p_wdog_wait;
    s_reg.state == ST_WAIT && !s_reg.wdog_dis |-> wdog_en;
  endproperty
  a_wdog_wait: assert property (p_wdog_wait) else $error("watchdog off in wait");

  property p_rec_hold;
    s_reg.state == ST_RECOV && s_reg.rcnt != rec_last |=> s_reg.state == ST_RECOV;
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("recovery ended early");

  property p_rec_count;
    s_reg.state == ST_RECOV && s_reg.xdiv == 2'h0 && s_reg.rcnt != rec_last |=>
      s_reg.rcnt == $past(s_reg.rcnt) + 13'h0001;
  endproperty
  a_rec_count: assert property (p_rec_count) else $error("recovery count wrong");

  // reset itself is watched, so the default disable is overridden here
  property p_rst_defaults;
    disable iff (1'b0) !rst_n |=> !int_take && cpu_clk_en && bus_clk_en && flag_clr_en;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("reset state wrong");

  c_hw_take: cover property (arb_ok ##1 int_take && vector_sel != VEC_SWI);
  c_wait_wake: cover property (s_reg.state == ST_WAIT ##1 int_take);
  c_stop_exit: cover property (s_reg.state == ST_RECOV ##1 s_reg.state == ST_RUN);
  c_brk: cover property ($rose(brk_state));

endmodule

/* verif/elpc_core_model.sv */
`timescale 1ns/100ps
// behavioural core: owns the mask bit and fetches the vector after a take
module elpc_core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic int_take,
  input wire logic restore_req,
  input wire logic clr_imask,
  input wire logic set_mask,
  input wire logic clr_mask,
  output logic i_mask,
  output logic vec_fetch
);
  logic [1:0] fetch_dly; // take to vector fetch delay line
  // mask bit and fetch sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      i_mask <= 1'b1;
      fetch_dly <= 2'h0;
    end else begin
      fetch_dly <= {fetch_dly[0], int_take};
      if (int_take || set_mask) begin
        i_mask <= 1'b1;
      end else if (restore_req || clr_imask || clr_mask) begin
        i_mask <= 1'b0;
      end
    end
  end
  assign vec_fetch = fetch_dly[1];
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import elpc_pkg::*;
  logic clock, rst_n, instr_done, swi_exec, rti_exec, wait_exec, stop_exec;
  logic i_mask, vec_fetch, brk_req, wr, rd, int_take, stack_pc_minus1, restore_req;
  logic clr_imask, brk_state, flag_clr_en, cpu_clk_en, per_clk_en, bus_clk_en;
  logic xtal_clk_en, wdog_en, set_mask, clr_mask;
  logic [15:0] irq_req, irq_en;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [4:0] vector_sel;
  int n_errors, tests_run, n;
  // short long recovery keeps the run brief
  elpc_ctrl #(.LONG_REC(8)) u_dut (.clock(clock), .rst_n(rst_n), .instr_done(instr_done),
    .i_mask(i_mask), .swi_exec(swi_exec), .rti_exec(rti_exec), .wait_exec(wait_exec),
    .stop_exec(stop_exec), .vec_fetch(vec_fetch), .brk_req(brk_req), .irq_req(irq_req),
    .irq_en(irq_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .int_take(int_take), .vector_sel(vector_sel), .stack_pc_minus1(stack_pc_minus1),
    .restore_req(restore_req), .clr_imask(clr_imask), .brk_state(brk_state),
    .flag_clr_en(flag_clr_en), .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
    .bus_clk_en(bus_clk_en), .xtal_clk_en(xtal_clk_en), .wdog_en(wdog_en));
  elpc_core_model u_core (.clock(clock), .rst_n(rst_n), .int_take(int_take),
    .restore_req(restore_req), .clr_imask(clr_imask), .set_mask(set_mask),
    .clr_mask(clr_mask), .i_mask(i_mask), .vec_fetch(vec_fetch));
  // free running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one-cycle register write
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // one-cycle read, data sampled in the following cycle
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // instruction boundary, kind is {swi, rti, wait, stop}
  task automatic boundary(input logic [3:0] kind);
    @(posedge clock);
    instr_done <= 1'b1;
    {swi_exec, rti_exec, wait_exec, stop_exec} <= kind;
    @(posedge clock);
    instr_done <= 1'b0;
    {swi_exec, rti_exec, wait_exec, stop_exec} <= 4'h0;
    #1;
  endtask
  // bounded wait for a take, counting cycles
  task automatic wait_take(input int lim);
    n = 0;
    while (int_take !== 1'b1) begin
      if (n >= lim) begin
        n_errors++;
        break;
      end
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // cut a hang short
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    {rst_n, instr_done, swi_exec, rti_exec, wait_exec, stop_exec} = 6'h00;
    {brk_req, wr, rd, set_mask, clr_mask} = 5'h00;
    irq_req = 16'h0000;
    irq_en = 16'h0000;
    addr = 3'h0;
    wdata = 8'h00;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    irq_req <= 16'hc3a5;
    reg_rd(ADDR_PEND_FIRST, d);
    chk(d, {irq_req[5:0], 2'b00});
    reg_wr(ADDR_PEND_SECOND, 8'hff);
    reg_rd(ADDR_PEND_SECOND, d);
    chk(d, irq_req[13:6]);
    reg_rd(ADDR_PEND_THIRD, d);
    chk(d, {6'h00, irq_req[15:14]});
    reg_rd(3'h7, d);
    chk(d, 8'h00);
    // two enabled sources pending, lower index wins
    irq_en <= 16'h0024;
    clr_mask <= 1'b1;
    boundary(4'h0);
    clr_mask <= 1'b0;
    chk({int_take, vector_sel, stack_pc_minus1}, {1'b1, 5'h03, 1'b1});
    repeat (4) @(posedge clock);
    boundary(4'h0);
    chk(int_take, 1'b0);
    boundary(4'h8);
    chk({int_take, vector_sel, stack_pc_minus1}, {1'b1, VEC_SWI, 1'b0});
    repeat (4) @(posedge clock);
    boundary(4'h4);
    chk(restore_req, 1'b1);
    boundary(4'h0);
    chk({int_take, vector_sel}, {1'b1, 5'h03});
    repeat (4) @(posedge clock);
    boundary(4'h4);
    // break takes the software vector and protects flags
    irq_en <= 16'h0000;
    brk_req <= 1'b1;
    boundary(4'h0);
    brk_req <= 1'b0;
    chk({int_take, vector_sel, brk_state}, {1'b1, VEC_SWI, 1'b1});
    chk(flag_clr_en, 1'b0);
    reg_wr(ADDR_BRK_FLAG_CTRL, 8'h80);
    #1;
    chk(flag_clr_en, 1'b1);
    reg_wr(ADDR_BRK_FLAG_CTRL, 8'h00);
    repeat (2) @(posedge clock);
    boundary(4'h4);
    chk(brk_state, 1'b0);
    // wait mode, woken by break
    boundary(4'h2);
    chk({clr_imask, cpu_clk_en, per_clk_en}, 3'h5);
    chk(wdog_en, 1'b1);
    @(posedge clock);
    brk_req <= 1'b1;
    #1;
    wait_take(8);
    chk(n, 1);
    brk_req <= 1'b0;
    reg_rd(ADDR_BRK_STATUS, d);
    chk(d[BIT_STOP_WAIT_FLAG], 1'b1);
    reg_wr(ADDR_BRK_STATUS, 8'h00);
    reg_rd(ADDR_BRK_STATUS, d);
    chk(d[BIT_STOP_WAIT_FLAG], 1'b0);
    repeat (2) @(posedge clock);
    boundary(4'h4);
    // stop with short recovery, then with the long one
    for (int k = 0; k < 2; k++) begin
      reg_wr(ADDR_CONFIG, (k == 0) ? 8'h01 : 8'h00);
      boundary(4'h1);
      chk({cpu_clk_en, per_clk_en, bus_clk_en, xtal_clk_en}, 4'h0);
      @(posedge clock);
      irq_en <= 16'h0001;
      #1;
      wait_take(300);
      chk({15'h0000, n >= ((k == 0) ? 62 : 14) && n <= ((k == 0) ? 70 : 22)}, 1);
      chk({vector_sel, bus_clk_en, cpu_clk_en}, {5'h01, 2'h3});
      irq_en <= 16'h0000;
      repeat (4) @(posedge clock);
    end
    // reset in the middle of stop ends it at once
    boundary(4'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({cpu_clk_en, per_clk_en, bus_clk_en, xtal_clk_en, int_take, brk_state}, 6'h3c);
    boundary(4'h8);
    chk({int_take, vector_sel}, {1'b1, VEC_SWI});
    // watchdog disabled by configuration
    reg_wr(ADDR_CONFIG, 8'h02);
    reg_rd(ADDR_CONFIG, d);
    chk({d, wdog_en}, {8'h02, 1'b0});
    test_done();
  end
endmodule
